/* File: include/pls_pkg.sv */
// shared constants of the position loop supervisor
package pls_pkg;

    // ------------------------------------------------------------
    // data widths
    // ------------------------------------------------------------
    localparam int POS_WIDTH = 32;
    localparam int MODE_WIDTH = 4;
    localparam int CFG_WIDTH = 16;
    localparam int DIAG_WIDTH = 16;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int DIAG_FOLLOW_ERR_BIT = 11;
    localparam int CFG_MODULO_BIT = 7;
    localparam int CFG_LIMIT_EN_BIT = 4;

    // ------------------------------------------------------------
    // position control operating modes
    // ------------------------------------------------------------
    localparam logic [MODE_WIDTH-1:0] MODE_POS_MOTOR = 4'h3;
    localparam logic [MODE_WIDTH-1:0] MODE_POS_DIRECT = 4'h4;
    localparam logic [MODE_WIDTH-1:0] MODE_POS_BOTH = 4'h5;
    localparam logic [MODE_WIDTH-1:0] MODE_POS_MOTOR_FF = 4'hB;
    localparam logic [MODE_WIDTH-1:0] MODE_POS_DIRECT_FF = 4'hC;
    localparam logic [MODE_WIDTH-1:0] MODE_POS_BOTH_FF = 4'hD;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [DIAG_WIDTH-1:0] DIAG_RESET = 16'h0000;

endpackage

/* File: rtl/pls_wrap.sv */
// folds a signed position into the range zero up to the modulus
`timescale 1ns/1ns
module pls_wrap #(
    parameter int W = 32
) (
    // value to fold
    input wire logic signed [W-1:0] value,
    input wire logic [W-1:0] modulus,
    // folded result
    output logic [W-1:0] wrapped
);
    // one fold step: the value is expected within one modulus of the range
    logic signed [W:0] v_ext;
    logic signed [W:0] m_ext;
    logic signed [W:0] sum;

    always_comb begin
        v_ext = {value[W-1], value};
        m_ext = {1'b0, modulus};
        if (modulus == '0) begin
            sum = v_ext;
        end else if (v_ext < 0) begin
            sum = v_ext + m_ext;
        end else if (v_ext >= m_ext) begin
            sum = v_ext - m_ext;
        end else begin
            sum = v_ext;
        end
        wrapped = sum[W-1:0];
    end
endmodule // pls_wrap

/* File: rtl/pls_supervisor.sv */
// position loop supervisor: following error, travel limits, modulo format
`timescale 1ns/1ns
module pls_supervisor #(
    parameter int W = pls_pkg::POS_WIDTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // loop cycle strobe and measured values
    input wire logic loop_tick,
    input wire logic signed [W-1:0] following_error_value,
    input wire logic signed [W-1:0] position_command_value,
    input wire logic signed [W-1:0] position_feedback_value,
    input wire logic signed [W-1:0] velocity_command_value,
    input wire logic torque_active_flag,
    // settings
    input wire logic [pls_pkg::MODE_WIDTH-1:0] operating_mode_select,
    input wire logic [pls_pkg::CFG_WIDTH-1:0] position_config_word,
    input wire logic [W-1:0] monitor_window_setting,
    input wire logic [W-1:0] wrap_modulus,
    input wire logic signed [W-1:0] upper_travel_limit,
    input wire logic signed [W-1:0] lower_travel_limit,
    input wire logic fault_clear,
    // faults and status
    output logic following_error_fault,
    output logic travel_limit_fault,
    output logic [pls_pkg::DIAG_WIDTH-1:0] diag_status_word,
    output logic command_blocked,
    output logic velocity_refused,
    // positions and velocity passed on to the loop
    output logic [W-1:0] position_command_out,
    output logic [W-1:0] position_feedback_out,
    output logic [W-1:0] velocity_command_out
);

    // ------------------------------------------------------------
    // modulo folding
    // ------------------------------------------------------------
    logic modulo_on;
    logic [W-1:0] cmd_wrapped;
    logic [W-1:0] fb_wrapped;

    assign modulo_on = position_config_word[pls_pkg::CFG_MODULO_BIT];

    pls_wrap #(.W(W)) u_wrap_cmd (
        .value(position_command_value),
        .modulus(wrap_modulus),
        .wrapped(cmd_wrapped)
    );

    pls_wrap #(.W(W)) u_wrap_fb (
        .value(position_feedback_value),
        .modulus(wrap_modulus),
        .wrapped(fb_wrapped)
    );

    // ------------------------------------------------------------
    // check terms
    // ------------------------------------------------------------
    logic position_mode;
    logic [W-1:0] fe_mag;
    logic [W-1:0] vel_mag;
    logic fe_check_on;
    logic fe_hit;
    logic signed [W-1:0] cmd_eval;
    logic [W-1:0] fb_eval;
    logic limits_on;
    logic limit_hit;
    logic vel_hit;

    always_comb begin
        position_mode = (operating_mode_select == pls_pkg::MODE_POS_MOTOR)
            || (operating_mode_select == pls_pkg::MODE_POS_DIRECT)
            || (operating_mode_select == pls_pkg::MODE_POS_BOTH)
            || (operating_mode_select == pls_pkg::MODE_POS_MOTOR_FF)
            || (operating_mode_select == pls_pkg::MODE_POS_DIRECT_FF)
            || (operating_mode_select == pls_pkg::MODE_POS_BOTH_FF);
        fe_mag = following_error_value[W-1] ? W'(-following_error_value) : W'(following_error_value);
        vel_mag = velocity_command_value[W-1] ? W'(-velocity_command_value) : W'(velocity_command_value);
        fe_check_on = position_mode
            && (monitor_window_setting != '0)
            && torque_active_flag;
        fe_hit = fe_check_on && (fe_mag > monitor_window_setting);
        cmd_eval = modulo_on ? $signed(cmd_wrapped) : position_command_value;
        fb_eval = modulo_on ? fb_wrapped : W'(position_feedback_value);
        limits_on = position_config_word[pls_pkg::CFG_LIMIT_EN_BIT]
            && !((upper_travel_limit == '0) && (lower_travel_limit == '0));
        limit_hit = limits_on
            && ((cmd_eval > upper_travel_limit) || (cmd_eval < lower_travel_limit));
        vel_hit = modulo_on && (vel_mag > wrap_modulus);
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic next_following_error_fault;
    logic next_travel_limit_fault;
    logic next_command_blocked;
    logic next_velocity_refused;
    logic [W-1:0] next_position_command_out;
    logic [W-1:0] next_position_feedback_out;
    logic [W-1:0] next_velocity_command_out;
    logic [pls_pkg::DIAG_WIDTH-1:0] next_diag_status_word;

    always_comb begin
        next_following_error_fault = following_error_fault && !fault_clear;
        next_travel_limit_fault = travel_limit_fault && !fault_clear;
        next_command_blocked = 1'b0;
        next_velocity_refused = 1'b0;
        next_position_command_out = position_command_out;
        next_position_feedback_out = position_feedback_out;
        next_velocity_command_out = velocity_command_out;
        if (loop_tick) begin
            // a new event wins over a clear in the same cycle
            if (fe_hit) begin
                next_following_error_fault = 1'b1;
            end
            if (limit_hit) begin
                next_travel_limit_fault = 1'b1;
                next_command_blocked = 1'b1;
            end else begin
                next_position_command_out = W'(cmd_eval);
            end
            next_position_feedback_out = fb_eval;
            if (vel_hit) begin
                next_velocity_refused = 1'b1;
            end else begin
                next_velocity_command_out = W'(velocity_command_value);
            end
        end
        next_diag_status_word = diag_status_word;
        next_diag_status_word[pls_pkg::DIAG_FOLLOW_ERR_BIT] = next_following_error_fault;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            following_error_fault <= 1'b0;
            travel_limit_fault <= 1'b0;
            command_blocked <= 1'b0;
            velocity_refused <= 1'b0;
            position_command_out <= '0;
            position_feedback_out <= '0;
            velocity_command_out <= '0;
            diag_status_word <= pls_pkg::DIAG_RESET;
        end else begin
            following_error_fault <= next_following_error_fault;
            travel_limit_fault <= next_travel_limit_fault;
            command_blocked <= next_command_blocked;
            velocity_refused <= next_velocity_refused;
            position_command_out <= next_position_command_out;
            position_feedback_out <= next_position_feedback_out;
            velocity_command_out <= next_velocity_command_out;
            diag_status_word <= next_diag_status_word;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_fe_armed;
        loop_tick && position_mode && (monitor_window_setting != '0) && torque_active_flag
            && (fe_mag > monitor_window_setting);
    endsequence

    sequence s_fe_rise;
        !following_error_fault ##1 following_error_fault;
    endsequence

    sequence s_limit_cmd;
        loop_tick && limits_on && ((cmd_eval > upper_travel_limit) || (cmd_eval < lower_travel_limit));
    endsequence

    a_fe_raise: assert property (s_fe_armed |=> following_error_fault)
        else $error("following error over window did not raise the fault");
    a_fe_diag_bit: assert property (diag_status_word[pls_pkg::DIAG_FOLLOW_ERR_BIT] == following_error_fault)
        else $error("diag bit 11 differs from the following error fault");
    a_fe_mode_gate: assert property (s_fe_rise |-> $past(position_mode))
        else $error("following error fault raised outside position mode");
    a_fe_window_zero: assert property (s_fe_rise |-> ($past(monitor_window_setting) != '0))
        else $error("following error fault raised with a zero window");
    a_fe_torque_gate: assert property (s_fe_rise |-> $past(torque_active_flag))
        else $error("following error fault raised without torque");
    a_wrap_range: assert property (loop_tick && modulo_on && (wrap_modulus != '0)
        |=> position_feedback_out < $past(wrap_modulus))
        else $error("modulo feedback left the range");
    a_abs_format_pass: assert property (loop_tick && !modulo_on && !limit_hit
        |=> position_command_out == W'($past(position_command_value)))
        else $error("absolute format command altered");
    // the pulse may only stay high when the next back to back tick is refused as well
    a_vel_refuse: assert property (loop_tick && vel_hit
        |=> velocity_refused && $stable(velocity_command_out)
        ##1 (!velocity_refused || $past(loop_tick && vel_hit)))
        else $error("over range velocity was not refused");
    a_limit_permit: assert property (loop_tick && !limit_hit |=> !command_blocked)
        else $error("permitted position was blocked");
    a_limit_raise: assert property (s_limit_cmd |=> travel_limit_fault && command_blocked
        && $stable(position_command_out))
        else $error("forbidden command did not raise the travel limit fault");
    a_limit_disable: assert property ($rose(travel_limit_fault)
        |-> $past(position_config_word[pls_pkg::CFG_LIMIT_EN_BIT])
        && (($past(upper_travel_limit) != '0) || ($past(lower_travel_limit) != '0)))
        else $error("travel limit fault raised while limits disabled");
    a_tick_only: assert property (!loop_tick |=> $stable(position_feedback_out)
        && $stable(position_command_out) && !command_blocked)
        else $error("loop values changed without a loop tick");

endmodule // pls_supervisor

/* File: verif/pls_cnc_model.sv */
// cnc model: issues one position loop cycle of commands per call
`timescale 1ns/1ns
module pls_cnc_model (
    // clock
    input wire logic core_clk,
    // loop commands
    output logic loop_tick,
    output logic signed [31:0] following_error_value,
    output logic signed [31:0] position_command_value,
    output logic signed [31:0] position_feedback_value,
    output logic signed [31:0] velocity_command_value
);
    initial begin
        loop_tick = 1'b0;
        following_error_value = 32'h0000_0000;
        position_command_value = 32'h0000_0000;
        position_feedback_value = 32'h0000_0000;
        velocity_command_value = 32'h0000_0000;
    end

    // unless keep is set, after the tick the values are inverted, so stale samples show up
    task automatic issue(input logic [31:0] p, input logic [31:0] e, input logic [31:0] f,
        input logic [31:0] v, input bit keep);
        @(negedge core_clk);
        loop_tick = 1'b1;
        position_command_value = p;
        following_error_value = e;
        position_feedback_value = f;
        velocity_command_value = v;
        if (!keep) begin
            @(negedge core_clk);
            loop_tick = 1'b0;
            position_command_value = ~p;
            following_error_value = ~e;
            position_feedback_value = ~f;
            velocity_command_value = ~v;
        end
    endtask
endmodule // pls_cnc_model

/* File: verif/testbench.sv */
// self-checking bench of the position loop supervisor
`timescale 1ns/1ns
module testbench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic torque_active_flag = 1'b1;
    logic fault_clear = 1'b0;
    logic [3:0] operating_mode_select = pls_pkg::MODE_POS_MOTOR;
    logic [15:0] position_config_word = 16'h0000;
    logic [31:0] monitor_window_setting = 32'h0000_0064;
    logic [31:0] wrap_modulus = 32'h0000_0168;
    logic signed [31:0] upper_travel_limit = 32'h0000_03E8;
    logic signed [31:0] lower_travel_limit = 32'hFFFF_FC18;
    logic loop_tick;
    logic signed [31:0] following_error_value, position_command_value;
    logic signed [31:0] position_feedback_value, velocity_command_value;
    logic following_error_fault, travel_limit_fault, command_blocked, velocity_refused;
    logic [15:0] diag_status_word;
    logic [31:0] position_command_out, position_feedback_out, velocity_command_out;
    int failures = 0;
    int samples_checked = 0;

    always #2 core_clk = ~core_clk;

    pls_cnc_model i_cnc (.core_clk, .loop_tick, .following_error_value, .position_command_value,
        .position_feedback_value, .velocity_command_value);
    pls_supervisor i_dut (.core_clk, .rst, .loop_tick, .following_error_value, .position_command_value,
        .position_feedback_value, .velocity_command_value, .torque_active_flag, .operating_mode_select,
        .position_config_word, .monitor_window_setting, .wrap_modulus, .upper_travel_limit,
        .lower_travel_limit, .fault_clear, .following_error_fault, .travel_limit_fault, .diag_status_word,
        .command_blocked, .velocity_refused, .position_command_out, .position_feedback_out,
        .velocity_command_out);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one tick; returns on the falling edge after it, while the one-cycle pulses still stand
    task automatic step(input logic [31:0] p, input logic [31:0] e, input logic [31:0] f, input logic [31:0] v);
        i_cnc.issue(p, e, f, v, 1'b0);
    endtask

    task automatic clr;
        fault_clear = 1'b1;
        @(negedge core_clk);
        fault_clear = 1'b0;
        chk({following_error_fault, travel_limit_fault, diag_status_word}, 18'h0_0000);
    endtask

    task automatic test_done;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_follow;
        step(32'h0000_0000, 32'h0000_0065, 32'h0000_0000, 32'h0000_0000);
        chk(following_error_fault, 1'b1);
        chk(diag_status_word, 16'h0800);
        clr();
        step(32'h0000_0000, 32'h0000_0064, 32'h0000_0000, 32'h0000_0000);
        chk(following_error_fault, 1'b0);
        step(32'h0000_0000, 32'hFFFF_FF9B, 32'h0000_0000, 32'h0000_0000);
        chk(following_error_fault, 1'b1);
        clr();
    endtask

    task automatic t_gate;
        for (int m = 0; m < 16; m++) begin
            operating_mode_select = m[3:0];
            step(32'h0000_0000, 32'h0000_0065, 32'h0000_0000, 32'h0000_0000);
            chk(following_error_fault, m[3:0] inside {pls_pkg::MODE_POS_MOTOR, pls_pkg::MODE_POS_DIRECT,
                pls_pkg::MODE_POS_BOTH, pls_pkg::MODE_POS_MOTOR_FF, pls_pkg::MODE_POS_DIRECT_FF,
                pls_pkg::MODE_POS_BOTH_FF});
            clr();
        end
        operating_mode_select = pls_pkg::MODE_POS_DIRECT;
        monitor_window_setting = 32'h0000_0000;
        step(32'h0000_0000, 32'h7FFF_0000, 32'h0000_0000, 32'h0000_0000);
        chk(following_error_fault, 1'b0);
        monitor_window_setting = 32'h0000_0064;
        torque_active_flag = 1'b0;
        step(32'h0000_0000, 32'h7FFF_0000, 32'h0000_0000, 32'h0000_0000);
        chk(following_error_fault, 1'b0);
        torque_active_flag = 1'b1;
    endtask

    task automatic t_limits;
        position_config_word = 16'h0010;
        step(32'h0000_03E8, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        chk({travel_limit_fault, command_blocked, position_command_out}, 34'h0_0000_03E8);
        step(32'hFFFF_FC18, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        chk({travel_limit_fault, command_blocked, position_command_out}, 34'h0_FFFF_FC18);
        step(32'h0000_03E9, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        chk({travel_limit_fault, command_blocked, position_command_out}, 34'h3_FFFF_FC18);
        @(negedge core_clk);
        chk({travel_limit_fault, command_blocked}, 2'b10);
        clr();
        step(32'hFFFF_FC17, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        chk({travel_limit_fault, command_blocked}, 2'b11);
        clr();
        position_config_word = 16'h0000;
        step(32'h0000_1388, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        chk({travel_limit_fault, command_blocked, position_command_out}, 34'h0_0000_1388);
        position_config_word = 16'h0010;
        upper_travel_limit = 32'h0000_0000;
        lower_travel_limit = 32'h0000_0000;
        step(32'h0000_1389, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        chk({travel_limit_fault, command_blocked, position_command_out}, 34'h0_0000_1389);
        position_config_word = 16'h0080;
    endtask

    task automatic t_modulo;
        step(32'h0000_0190, 32'h0000_0000, 32'h0000_0172, 32'h0000_0169);
        chk({position_command_out, position_feedback_out}, 64'h0000_0028_0000_000A);
        chk({velocity_refused, velocity_command_out}, 33'h1_0000_0000);
        step(32'hFFFF_FFF6, 32'h0000_0000, 32'h0000_0000, 32'hFFFF_FE98);
        chk(position_command_out, 32'h0000_015E);
        chk({velocity_refused, velocity_command_out}, 33'h0_FFFF_FE98);
        step(32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'hFFFF_FE97);
        chk({velocity_refused, velocity_command_out}, 33'h1_FFFF_FE98);
        position_config_word = 16'h0000;
        step(32'h0000_0190, 32'h0000_0000, 32'h0000_0172, 32'h0000_0169);
        chk({position_command_out, position_feedback_out}, 64'h0000_0190_0000_0172);
        chk({velocity_refused, velocity_command_out}, 33'h0_0000_0169);
    endtask

    task automatic t_loop;
        i_cnc.issue(32'h0000_0011, 32'h0000_0065, 32'h0000_0000, 32'h0000_0000, 1'b1);
        i_cnc.issue(32'h0000_0022, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 1'b0);
        chk({following_error_fault, position_command_out}, 33'h1_0000_0022);
        repeat (6) @(negedge core_clk);
        chk(position_command_out, 32'h0000_0022);
        clr();
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        chk({following_error_fault, travel_limit_fault, diag_status_word, position_command_out}, 50'h0);
        t_follow();
        t_gate();
        t_limits();
        t_modulo();
        t_loop();
        test_done();
    end

    initial begin
        #100000;
        failures++;
        test_done();
    end
endmodule // testbench
